// File: sprm_buf2.sv
`timescale 1ns/100ps
`default_nettype none

module sprm_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Filling side
  input  wire logic             s_valid,
  input  wire logic [WIDTH-1:0] s_data,
  output logic                  s_ready,
  // Draining side
  input  wire logic             m_ready,
  output logic                  m_valid,
  output logic [WIDTH-1:0]      m_data
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;
  logic [CW-1:0]    next_count;

  if (DEPTH < 2 || WIDTH < 1) begin : g_check
    $error("sprm_buf2 needs DEPTH >= 2 and WIDTH >= 1");
  end

  assign push       = s_valid && s_ready;
  assign pop        = m_valid && m_ready;
  assign next_count = count + CW'(push) - CW'(pop);
  assign m_data     = mem[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count   <= '0;
      s_ready <= 1'b0;
      m_valid <= 1'b0;
    end else begin
      count   <= next_count;
      // Ready is exact room for the next cycle, so no word is ever lost
      s_ready <= (next_count != CW'(DEPTH));
      m_valid <= (next_count != '0);
    end
  end

  // Head always sits in entry 0, so the output data is a plain flop
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge aclk) begin
      if (pop && (i < DEPTH - 1) && (CW'(i + 1) < count)) begin
        mem[i] <= mem[i+1];
      end
      if (push && (count - CW'(pop) == CW'(i))) begin
        mem[i] <= s_data;
      end
    end
  end

endmodule

`default_nettype wire

// File: sprm_ctrl.sv
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module sprm_ctrl
  import sprm_pkg::*;
#(
  parameter int TW    = 16,
  parameter int DW    = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address and data
  input  wire logic                   awvalid,
  input  wire logic [SPRM_ADDR_W-1:0] awaddr,
  output logic                        awready,
  input  wire logic                   wvalid,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  output logic                        wready,
  // AXI4-Lite write response
  output logic                        bvalid,
  output logic [1:0]                  bresp,
  input  wire logic                   bready,
  // AXI4-Lite read
  input  wire logic                   arvalid,
  input  wire logic [SPRM_ADDR_W-1:0] araddr,
  output logic                        arready,
  output logic                        rvalid,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  input  wire logic                   rready,
  // Receiver status from neighbouring units
  input  wire logic                   wake_ok,
  input  wire logic                   wake_rssi_ok,
  input  wire logic                   wake_cfg_b,
  input  wire logic                   sync_found,
  input  wire logic                   sync_lost,
  input  wire logic                   mid_match,
  input  wire logic                   eom_detect,
  // Received payload stream
  input  wire logic                   in_valid,
  input  wire logic [DW-1:0]          in_data,
  output logic                        in_ready,
  // Receive FIFO write side
  output logic                        fifo_init,
  output logic                        fifo_wr_valid,
  output logic [DW-1:0]               fifo_wr_data,
  input  wire logic                   fifo_wr_ready,
  // Control towards the receiver
  output logic                        modulation_sel,
  output logic                        mid_scan_en,
  output logic                        sync_search_en,
  output logic                        poll_active,
  output logic                        self_poll_run_state,
  output logic                        host_run_mode,
  output logic                        sleep_active,
  // Host events
  output logic                        frame_start_evt,
  output logic                        mid_evt,
  output logic                        eom_evt
);

  if (TW < 1 || TW > 32 || DW < 1 || DEPTH < 2) begin : g_check
    $error("sprm_ctrl: TW 1..32, DW >= 1 and DEPTH >= 2 required");
  end

  sprm_state_t                state;
  sprm_state_t                next_state;
  sprm_cause_t                cause;
  sprm_cause_t                next_cause;
  logic [SPRM_CTRL_W-1:0]     ctrl;
  logic [SPRM_EV_W-1:0]       mask;
  logic [TW-1:0]              sync_to;
  logic [TW-1:0]              tsi_to_a;
  logic [TW-1:0]              tsi_to_b;
  logic [TW-1:0]              eom_to_a;
  logic [TW-1:0]              eom_to_b;
  logic                       cfg_b;
  logic                       synced;
  logic                       lost;
  logic [TW-1:0]              run_cnt;
  logic [TW-1:0]              lost_cnt;
  logic                       in_run;
  logic                       tsi_limit;
  logic                       eom_limit;
  logic                       lost_limit;
  logic                       buf_valid;
  logic                       aw_hold;
  logic                       w_hold;
  logic [SPRM_ADDR_W-1:0]     aw_addr;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic [31:0]                wr_word;
  logic [31:0]                rd_word;
  logic                       rd_hit;
  logic                       wr_hit;

  assign in_run = (state == SPRM_S_MOD_SW) || (state == SPRM_S_WAIT_SYNC)
               || (state == SPRM_S_FIFO_INIT) || (state == SPRM_S_PAYLOAD);

  // Zero in a TSI or EOM timeout register disables that guard; a zero sync_to ends the run as soon as sync is lost
  // per-config TSI and EOM limits; the sync-loss limit is shared
  assign tsi_limit  = !synced && ((cfg_b ? tsi_to_b : tsi_to_a) != '0)
                   && (run_cnt >= (cfg_b ? tsi_to_b : tsi_to_a));
  assign eom_limit  = ((cfg_b ? eom_to_b : eom_to_a) != '0)
                   && (run_cnt >= (cfg_b ? eom_to_b : eom_to_a));
  assign lost_limit = lost && (lost_cnt >= sync_to);

  always_comb begin
    next_state = state;
    next_cause = cause;
    if (!ctrl[SPRM_CTRL_MODE_SEL]) begin
      next_state = ctrl[SPRM_CTRL_SLRX_EN] ? SPRM_S_HOST_RUN : SPRM_S_SLEEP;
      if (in_run) begin
        next_cause = SPRM_X_HOST;
      end
    end else if (!in_run) begin
      next_state = SPRM_S_POLL;
      if (state == SPRM_S_POLL && (wake_ok || wake_rssi_ok)) begin
        next_state = SPRM_S_MOD_SW;
      end
    end else if (lost_limit || tsi_limit || eom_limit) begin
      next_state = SPRM_S_POLL;
      next_cause = lost_limit ? SPRM_X_SYNC_LOSS :
                   tsi_limit  ? SPRM_X_TSI_TO    : SPRM_X_EOM_TO;
    end else begin
      case (state)
        SPRM_S_MOD_SW: next_state = SPRM_S_WAIT_SYNC;
        SPRM_S_WAIT_SYNC: begin
          if (sync_found) begin
            next_state = SPRM_S_FIFO_INIT;
          end
        end
        SPRM_S_FIFO_INIT: next_state = SPRM_S_PAYLOAD;
        SPRM_S_PAYLOAD: begin
          if (eom_detect && ctrl[SPRM_CTRL_RET_EOM]) begin
            next_state = SPRM_S_POLL;
            next_cause = SPRM_X_EOM;
          end
        end
        default: next_state = SPRM_S_POLL;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SPRM_S_SLEEP;
      cause <= SPRM_X_NONE;
    end else begin
      state <= next_state;
      cause <= next_cause;
    end
  end

  // Frame and sync tracking inside the run state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_b  <= 1'b0;
      synced <= 1'b0;
      lost   <= 1'b0;
    end else begin
      if (state == SPRM_S_POLL && next_state == SPRM_S_MOD_SW) begin
        cfg_b <= wake_cfg_b;
      end
      if (next_state == SPRM_S_FIFO_INIT) begin
        synced <= 1'b1;
      end else if (next_state != SPRM_S_PAYLOAD) begin
        synced <= 1'b0;
      end
      if (next_state != SPRM_S_PAYLOAD || sync_found) begin
        lost <= 1'b0;
      end else if (sync_lost) begin
        lost <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !in_run) begin
      run_cnt  <= '0;
      lost_cnt <= '0;
    end else begin
      if (run_cnt != '1) begin
        run_cnt <= run_cnt + TW'(1);
      end
      if (!lost) begin
        lost_cnt <= '0;
      end else if (lost_cnt != '1) begin
        lost_cnt <= lost_cnt + TW'(1);
      end
    end
  end

  // Receiver control outputs, all from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modulation_sel      <= 1'b0;
      fifo_init           <= 1'b0;
      mid_scan_en         <= 1'b0;
      sync_search_en      <= 1'b0;
      poll_active         <= 1'b0;
      self_poll_run_state <= 1'b0;
      host_run_mode       <= 1'b0;
      sleep_active        <= 1'b1;
    end else begin
      if (next_state == SPRM_S_POLL) begin
        modulation_sel <= ctrl[SPRM_CTRL_MT_WAKE];
      end else if (next_state == SPRM_S_MOD_SW) begin
        modulation_sel <= ctrl[SPRM_CTRL_AUTO_MOD] ? ctrl[SPRM_CTRL_MT_RUN]
                                                  : ctrl[SPRM_CTRL_MT_WAKE];
      end else if (next_state == SPRM_S_HOST_RUN) begin
        modulation_sel <= ctrl[SPRM_CTRL_MT_RUN];
      end
      fifo_init           <= (next_state == SPRM_S_FIFO_INIT);
      mid_scan_en         <= (next_state == SPRM_S_PAYLOAD)
                          && ctrl[SPRM_CTRL_MID_EN];
      sync_search_en      <= (next_state == SPRM_S_WAIT_SYNC);
      poll_active         <= (next_state == SPRM_S_POLL);
      self_poll_run_state <= (next_state == SPRM_S_MOD_SW)
                          || (next_state == SPRM_S_WAIT_SYNC)
                          || (next_state == SPRM_S_FIFO_INIT)
                          || (next_state == SPRM_S_PAYLOAD);
      host_run_mode       <= (next_state == SPRM_S_HOST_RUN);
      sleep_active        <= (next_state == SPRM_S_SLEEP);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_start_evt <= 1'b0;
      mid_evt         <= 1'b0;
      eom_evt         <= 1'b0;
    end else begin
      frame_start_evt <= (next_state == SPRM_S_FIFO_INIT)
                      && mask[SPRM_EV_FRAME];
      mid_evt         <= (state == SPRM_S_PAYLOAD) && mid_match
                      && ctrl[SPRM_CTRL_MID_EN] && mask[SPRM_EV_MID];
      eom_evt         <= (state == SPRM_S_PAYLOAD) && eom_detect
                      && mask[SPRM_EV_EOM];
    end
  end

  // payload into FIFO
  // Words offered outside a frame are taken and dropped while in_ready is high, but
  // in_ready follows the buffer, so the demodulator stalls while the buffer is full.
  assign buf_valid = in_valid && (state == SPRM_S_PAYLOAD);

  sprm_buf2 #(
    .WIDTH (DW),
    .DEPTH (DEPTH)
  ) u_buf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .s_valid (buf_valid),
    .s_data  (in_data),
    .s_ready (in_ready),
    .m_ready (fifo_wr_ready),
    .m_valid (fifo_wr_valid),
    .m_data  (fifo_wr_data)
  );

  // AXI4-Lite slave
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = '0;
    case (araddr)
      SPRM_CTRL_OFS:     rd_word[SPRM_CTRL_W-1:0] = ctrl;
      SPRM_MASK_OFS:     rd_word[SPRM_EV_W-1:0]   = mask;
      SPRM_SYNC_TO_OFS:  rd_word[TW-1:0]          = sync_to;
      SPRM_TSI_TO_A_OFS: rd_word[TW-1:0]          = tsi_to_a;
      SPRM_TSI_TO_B_OFS: rd_word[TW-1:0]          = tsi_to_b;
      SPRM_EOM_TO_A_OFS: rd_word[TW-1:0]          = eom_to_a;
      SPRM_EOM_TO_B_OFS: rd_word[TW-1:0]          = eom_to_b;
      SPRM_STATUS_OFS: begin
        rd_word[SPRM_ST_STATE +: 7] = state;
        rd_word[SPRM_ST_CAUSE +: 3] = cause;
        rd_word[SPRM_ST_SYNCED]     = synced;
        rd_word[SPRM_ST_LOST]       = lost;
        rd_word[SPRM_ST_CFG_B]      = cfg_b;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    wr_word = '0;
    for (int i = 0; i < 4; i++) begin
      wr_word[8*i +: 8] = w_strb[i] ? w_data[8*i +: 8] : 8'h00;
    end
  end

  assign wr_hit = (aw_addr[1:0] == 2'h0) && (aw_addr <= SPRM_STATUS_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= SPRM_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        wready <= 1'b0;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (aw_hold && w_hold && !bvalid) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (wr_hit && aw_addr != SPRM_STATUS_OFS) ? SPRM_RESP_OKAY
                                                          : SPRM_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Unstrobed timer bytes are written as zero; byte 0 gates CTRL and MASK
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl     <= SPRM_CTRL_RST;
      mask     <= SPRM_MASK_RST;
      sync_to  <= '0;
      tsi_to_a <= '0;
      tsi_to_b <= '0;
      eom_to_a <= '0;
      eom_to_b <= '0;
    end else if (aw_hold && w_hold && !bvalid) begin
      case (aw_addr)
        SPRM_CTRL_OFS: ctrl <= w_strb[0] ? wr_word[SPRM_CTRL_W-1:0]
                                         : ctrl;
        SPRM_MASK_OFS: mask <= w_strb[0] ? wr_word[SPRM_EV_W-1:0]
                                         : mask;
        SPRM_SYNC_TO_OFS:  sync_to  <= TW'(wr_word);
        SPRM_TSI_TO_A_OFS: tsi_to_a <= TW'(wr_word);
        SPRM_TSI_TO_B_OFS: tsi_to_b <= TW'(wr_word);
        SPRM_EOM_TO_A_OFS: eom_to_a <= TW'(wr_word);
        SPRM_EOM_TO_B_OFS: eom_to_b <= TW'(wr_word);
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= SPRM_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= rd_hit ? SPRM_RESP_OKAY : SPRM_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: sprm_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module sprm_ctrl_assertions #(
  parameter int TW    = 16,
  parameter int DW    = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // Bus handshakes
  input wire logic          awready,
  input wire logic          arvalid,
  input wire logic          arready,
  input wire logic          rvalid,
  // Receiver status
  input wire logic          wake_ok,
  input wire logic          wake_rssi_ok,
  input wire logic          sync_found,
  input wire logic          mid_match,
  input wire logic          eom_detect,
  // FIFO write side
  input wire logic          fifo_init,
  input wire logic          fifo_wr_valid,
  input wire logic [DW-1:0] fifo_wr_data,
  input wire logic          fifo_wr_ready,
  // Mode and events
  input wire logic          sync_search_en,
  input wire logic          mid_scan_en,
  input wire logic          poll_active,
  input wire logic          self_poll_run_state,
  input wire logic          host_run_mode,
  input wire logic          sleep_active,
  input wire logic          frame_start_evt,
  input wire logic          mid_evt,
  input wire logic          eom_evt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A pending register write may change the mode, so it is excluded
  sequence s_woken;
    poll_active && wake_ok && awready;
  endsequence
  sequence s_synced;
    sync_search_en && sync_found && awready;
  endsequence

  AST_WAKE_ENTRY: assert property (s_woken |=> self_poll_run_state)
    else $error("no run state after wake-up");
  AST_RSSI_ENTRY: assert property (
    poll_active && wake_rssi_ok && awready |=> self_poll_run_state)
    else $error("no run state after strength wake-up");
  AST_SYNC_WAIT: assert property (sync_search_en |-> self_poll_run_state)
    else $error("sync search outside run state");
  AST_FIFO_INIT: assert property (s_synced |=> fifo_init ##1 !fifo_init)
    else $error("fifo init not a single pulse after sync");
  AST_FRAME_EVT: assert property (frame_start_evt |-> fifo_init)
    else $error("frame event without frame start");
  AST_MID_EVT: assert property (mid_evt |-> $past(mid_match))
    else $error("identifier event without match");
  AST_EOM_EVT: assert property (eom_evt |-> $past(eom_detect))
    else $error("end event without end of message");
  AST_MID_SCAN: assert property (
    mid_scan_en |-> self_poll_run_state && !sync_search_en)
    else $error("identifier scan outside payload");
  AST_ONE_MODE: assert property (
    $onehot0({sleep_active, poll_active, host_run_mode, self_poll_run_state}))
    else $error("more than one mode active");
  AST_STALL_HOLD: assert property (
    fifo_wr_valid && !fifo_wr_ready |=> fifo_wr_valid && $stable(fifo_wr_data))
    else $error("fifo word changed while stalled");
  AST_READ_ANS: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
endmodule

bind sprm_ctrl sprm_ctrl_assertions #(.TW(TW), .DW(DW), .DEPTH(DEPTH)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .awready(awready), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .wake_ok(wake_ok),
  .wake_rssi_ok(wake_rssi_ok), .sync_found(sync_found),
  .mid_match(mid_match), .eom_detect(eom_detect), .fifo_init(fifo_init),
  .fifo_wr_valid(fifo_wr_valid), .fifo_wr_data(fifo_wr_data),
  .fifo_wr_ready(fifo_wr_ready), .sync_search_en(sync_search_en),
  .mid_scan_en(mid_scan_en), .poll_active(poll_active),
  .self_poll_run_state(self_poll_run_state), .host_run_mode(host_run_mode),
  .sleep_active(sleep_active), .frame_start_evt(frame_start_evt),
  .mid_evt(mid_evt), .eom_evt(eom_evt));

`default_nettype wire

// File: sprm_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
`define WAITF(c) begin for (k = 0; k < 300 && !(c); k++) @(posedge aclk); \
  if (!(c)) tmo(); end

module sprm_ctrl_bench
  import sprm_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0, hold = 1'b0;
  logic        wake_ok = 1'b0, wake_rssi_ok = 1'b0, sync_found = 1'b0;
  logic        sync_lost = 1'b0, mid_match = 1'b0, eom_detect = 1'b0;
  logic        in_valid = 1'b0, wake_cfg_b = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, in_data = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, in_ready, fifo_init;
  logic        fifo_wr_valid, fifo_wr_ready, modulation_sel, mid_scan_en;
  logic        sync_search_en, poll_active, self_poll_run_state;
  logic        host_run_mode, sleep_active, frame_start_evt, mid_evt, eom_evt;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  fifo_wr_data;
  int          n_fail = 0, cmp_count = 0, k, n_got, n_bad;

  sprm_ctrl u_sprm_ctrl (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awaddr(awaddr), .awready(awready), .wvalid(wvalid), .wdata(wdata),
    .wstrb(wstrb), .wready(wready), .bvalid(bvalid), .bresp(bresp),
    .bready(bready), .arvalid(arvalid), .araddr(araddr), .arready(arready),
    .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready),
    .wake_ok(wake_ok), .wake_rssi_ok(wake_rssi_ok), .wake_cfg_b(wake_cfg_b),
    .sync_found(sync_found), .sync_lost(sync_lost), .mid_match(mid_match),
    .eom_detect(eom_detect), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .fifo_init(fifo_init),
    .fifo_wr_valid(fifo_wr_valid), .fifo_wr_data(fifo_wr_data),
    .fifo_wr_ready(fifo_wr_ready), .modulation_sel(modulation_sel),
    .mid_scan_en(mid_scan_en), .sync_search_en(sync_search_en),
    .poll_active(poll_active), .self_poll_run_state(self_poll_run_state),
    .host_run_mode(host_run_mode), .sleep_active(sleep_active),
    .frame_start_evt(frame_start_evt), .mid_evt(mid_evt), .eom_evt(eom_evt));

  sprm_fifo_sink u_sprm_fifo_sink (.aclk(aclk), .aresetn(aresetn),
    .fifo_init(fifo_init), .wr_valid(fifo_wr_valid), .wr_data(fifo_wr_data),
    .wr_ready(fifo_wr_ready), .hold(hold), .n_got(n_got), .n_bad(n_bad));

  initial begin
    forever #10 aclk = ~aclk;
  end

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tmo();
    n_fail++;
    $display("[ERR] wait exp done got timeout");
    results();
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int j;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d;
    wstrb <= 4'hf; bready <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (!bvalid) tmo();
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] m, e,
                     input logic [1:0] er);
    int j;
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (!rvalid) tmo();
    rready <= 1'b0;
    `CHK("rresp", er, rresp)
    `CHK("rdata", e, rdata & m)
  endtask

  task automatic send(input logic [7:0] d);
    int j;
    @(posedge aclk);
    in_valid <= 1'b1; in_data <= d;
    for (j = 0; j < 100; j++) begin
      @(posedge aclk);
      if (in_ready) break;
    end
    if (!in_ready) tmo();
    in_valid <= 1'b0;
  endtask

  task automatic wake();
    @(posedge aclk) wake_ok <= 1'b1;
    @(posedge aclk) wake_ok <= 1'b0;
  endtask

  task automatic sync_up();
    `WAITF(sync_search_en)
    @(posedge aclk) sync_found <= 1'b1;
    @(posedge aclk) sync_found <= 1'b0;
    `WAITF(fifo_init)
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK("sleep", 1'b1, sleep_active)
    axr(SPRM_CTRL_OFS, 32'h7f, 32'h0, SPRM_RESP_OKAY);
    axr(SPRM_MASK_OFS, 32'h7, 32'h0, SPRM_RESP_OKAY);
    axr(SPRM_STATUS_OFS, 32'h7ff, 32'h001, SPRM_RESP_OKAY);
    axr(8'h20, 32'hffffffff, 32'h0, SPRM_RESP_SLVERR);
    axw(SPRM_STATUS_OFS, 32'h0, SPRM_RESP_SLVERR);
    axw(SPRM_MASK_OFS, 32'h7, SPRM_RESP_OKAY);
    axw(SPRM_SYNC_TO_OFS, 32'h5, SPRM_RESP_OKAY);
    axw(SPRM_TSI_TO_A_OFS, 32'h14, SPRM_RESP_OKAY);
    axw(SPRM_EOM_TO_A_OFS, 32'h0, SPRM_RESP_OKAY);
    axw(SPRM_CTRL_OFS, 32'h3d, SPRM_RESP_OKAY);
    axr(SPRM_CTRL_OFS, 32'h7f, 32'h3d, SPRM_RESP_OKAY);
    `WAITF(poll_active)
    `CHK("mod_wake", 1'b1, modulation_sel)
    $display("test registers done");

    // Interferer without sync word: the guard timer must end the run
    wake();
    `WAITF(sync_search_en)
    `CHK("mod_run", 1'b0, modulation_sel)
    `CHK("run", 1'b1, self_poll_run_state)
    `WAITF(poll_active)
    `CHK("tsi_wait", 1'b1, k >= 16 && k <= 22)
    axr(SPRM_STATUS_OFS, 32'h7ff, 32'h202, SPRM_RESP_OKAY);
    // Config B wake-up must use its own, shorter sync-word limit
    axw(SPRM_TSI_TO_B_OFS, 32'h8, SPRM_RESP_OKAY);
    wake_cfg_b <= 1'b1;
    wake();
    wake_cfg_b <= 1'b0;
    `WAITF(sync_search_en)
    `WAITF(poll_active)
    `CHK("tsi_b", 1'b1, k >= 4 && k <= 10)
    axr(SPRM_STATUS_OFS, 32'h27ff, 32'h2202, SPRM_RESP_OKAY);
    $display("test sync word timeout done");

    @(posedge aclk) wake_rssi_ok <= 1'b1;
    @(posedge aclk) wake_rssi_ok <= 1'b0;
    sync_up();
    `CHK("frame_evt", 1'b1, frame_start_evt)
    hold <= 1'b1;
    send(8'ha0);
    send(8'ha1);
    repeat (2) @(posedge aclk);
    `CHK("in_ready", 1'b0, in_ready)
    hold <= 1'b0;
    send(8'ha2);
    `WAITF(n_got == 3)
    `CHK("order", 0, n_bad)
    `CHK("mid_scan", 1'b1, mid_scan_en)
    @(posedge aclk) mid_match <= 1'b1;
    @(posedge aclk) mid_match <= 1'b0;
    `WAITF(mid_evt)
    @(posedge aclk) eom_detect <= 1'b1;
    @(posedge aclk) eom_detect <= 1'b0;
    `WAITF(eom_evt)
    `WAITF(poll_active)
    axr(SPRM_STATUS_OFS, 32'h7ff, 32'h402, SPRM_RESP_OKAY);
    $display("test payload done");

    wake();
    sync_up();
    @(posedge aclk) sync_lost <= 1'b1;
    @(posedge aclk) sync_lost <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK("run_held", 1'b1, self_poll_run_state)
    `WAITF(poll_active)
    axr(SPRM_STATUS_OFS, 32'h7ff, 32'h102, SPRM_RESP_OKAY);
    $display("test sync loss done");

    wake();
    `WAITF(sync_search_en)
    axw(SPRM_CTRL_OFS, 32'h2, SPRM_RESP_OKAY);
    `WAITF(host_run_mode)
    `CHK("run_left", 1'b0, self_poll_run_state)
    axr(SPRM_STATUS_OFS, 32'h7ff, 32'h504, SPRM_RESP_OKAY);
    $display("test host command done");
    results();
  end
endmodule

`default_nettype wire

// File: sprm_fifo_sink.sv
`timescale 1ns/100ps
`default_nettype none

module sprm_fifo_sink #(
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // FIFO write side
  input  wire logic          fifo_init,
  input  wire logic          wr_valid,
  input  wire logic [DW-1:0] wr_data,
  output logic               wr_ready,
  // Bench control and tallies
  input  wire logic          hold,
  output var int             n_got,
  output var int             n_bad
);
  logic          ph;
  logic [DW-1:0] expect_d;

  // Stalls every other cycle so the buffer must keep its words
  always_ff @(posedge aclk) begin
    ph <= aresetn ? ~ph : 1'b0;
  end
  assign wr_ready = ph & ~hold;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_got    <= 0;
      n_bad    <= 0;
      expect_d <= 8'ha0;
    end else if (fifo_init) begin
      expect_d <= 8'ha0;
    end else if (wr_valid && wr_ready) begin
      n_got    <= n_got + 1;
      n_bad    <= n_bad + ((wr_data !== expect_d) ? 1 : 0);
      expect_d <= expect_d + 8'h01;
    end
  end
endmodule

`default_nettype wire

// File: sprm_pkg.sv
package sprm_pkg;

  // Register byte offsets
  localparam logic [7:0] SPRM_CTRL_OFS     = 8'h00;
  localparam logic [7:0] SPRM_MASK_OFS     = 8'h04;
  localparam logic [7:0] SPRM_SYNC_TO_OFS  = 8'h08;
  localparam logic [7:0] SPRM_TSI_TO_A_OFS = 8'h0c;
  localparam logic [7:0] SPRM_TSI_TO_B_OFS = 8'h10;
  localparam logic [7:0] SPRM_EOM_TO_A_OFS = 8'h14;
  localparam logic [7:0] SPRM_EOM_TO_B_OFS = 8'h18;
  localparam logic [7:0] SPRM_STATUS_OFS   = 8'h1c;
  localparam int         SPRM_ADDR_W       = 8;

  // Control register fields
  localparam int SPRM_CTRL_MODE_SEL  = 0;
  localparam int SPRM_CTRL_SLRX_EN   = 1;
  localparam int SPRM_CTRL_RET_EOM   = 2;
  localparam int SPRM_CTRL_MID_EN    = 3;
  localparam int SPRM_CTRL_AUTO_MOD  = 4;
  localparam int SPRM_CTRL_MT_WAKE   = 5;
  localparam int SPRM_CTRL_MT_RUN    = 6;
  localparam int SPRM_CTRL_W         = 7;
  localparam logic [6:0] SPRM_CTRL_RST = 7'h00;

  // Event mask fields, a set bit passes the event
  localparam int SPRM_EV_FRAME = 0;
  localparam int SPRM_EV_MID   = 1;
  localparam int SPRM_EV_EOM   = 2;
  localparam int SPRM_EV_W     = 3;
  localparam logic [2:0] SPRM_MASK_RST = 3'h0;

  // Status register fields
  localparam int SPRM_ST_STATE  = 0;
  localparam int SPRM_ST_CAUSE  = 8;
  localparam int SPRM_ST_SYNCED = 11;
  localparam int SPRM_ST_LOST   = 12;
  localparam int SPRM_ST_CFG_B  = 13;

  localparam logic [1:0] SPRM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SPRM_RESP_SLVERR = 2'h2;

  typedef enum logic [6:0] {
    SPRM_S_SLEEP     = 7'h01,
    SPRM_S_POLL      = 7'h02,
    SPRM_S_HOST_RUN  = 7'h04,
    SPRM_S_MOD_SW    = 7'h08,
    SPRM_S_WAIT_SYNC = 7'h10,
    SPRM_S_FIFO_INIT = 7'h20,
    SPRM_S_PAYLOAD   = 7'h40
  } sprm_state_t;

  typedef enum logic [2:0] {
    SPRM_X_NONE      = 3'h0,
    SPRM_X_SYNC_LOSS = 3'h1,
    SPRM_X_TSI_TO    = 3'h2,
    SPRM_X_EOM_TO    = 3'h3,
    SPRM_X_EOM       = 3'h4,
    SPRM_X_HOST      = 3'h5
  } sprm_cause_t;

endpackage
